/* File: src/mma_pkg.sv */
/*
 * Constants and types shared by the memory map and shared RAM arbiter.
 * Assumes a 100 MHz subsystem clock and 16-bit memory words.
 */
package mma_pkg;

  // Block geometry of local and shared memory
  localparam int unsigned LOCAL_OFF_W   = 14;
  localparam int unsigned LOCAL_BLOCKS  = 6;
  localparam int unsigned LOCAL_WORDS   = LOCAL_BLOCKS << LOCAL_OFF_W;
  localparam int unsigned SHARED_OFF_W  = 15;
  localparam int unsigned SHARED_BLOCKS = 4;
  localparam int unsigned SHARED_WORDS  = SHARED_BLOCKS << SHARED_OFF_W;

  // Address widths
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned PADDR_W = 18;
  localparam int unsigned MADDR_W = 17;

  // Block selection
  localparam logic [2:0] DATA_UPPER_BASE = 3'h2;
  localparam logic [1:0] PROG_LOW_PAGE   = 2'h3;

  // Values after reset
  localparam logic OVERLAY_RST   = 1'b0;
  localparam logic PAGE_SEL_RST  = 1'b0;

  // Memory bus transfer length in cycles
  localparam int unsigned MBUS_CYCLES = 2;

  typedef enum logic [2:0] {
    MB_IDLE   = 3'b001,
    MB_FIRST  = 3'b010,
    MB_SECOND = 3'b100
  } mma_mbus_e;

endpackage

/* File: src/mma_map_arbiter.sv */
/*
 * Memory map decoder and shared program RAM arbiter for one pair of
 * subsystems. Holds each CPU's six local dual-access RAM blocks and the
 * four-block shared program RAM of the pair.
 * Assumes CPU and memory bus strobes come from logic on the same clock,
 * and that the memory bus offers one-cycle requests only while ready.
 */
`timescale 1ns/1ps

// Contract
// - Local memory decoded in 16K-word blocks.
// - Shared memory decoded in 32K-word blocks.
// - Page select 0: upper data to blocks 2,3.
// - Page select 1: upper data to blocks 4,5.
// - Overlay on: lower data visible in program space.
// - Overlay off: lower program from shared page 3.
// - Overlay enable cleared at reset.
// - Setting overlay bit shows lower RAM to program.
// - Six 16K-word dual-access blocks per subsystem.
// - Local blocks 0,1 take a data and an overlay program access per cycle.
// - 128K shared program words in four 32K blocks.
// - Both CPUs fetch shared RAM same cycle.
// - CPU writes to shared RAM are rejected.
// - Memory bus has priority, stalls shared CPU fetches.
// - Memory bus transfer takes exactly two cycles.
// - Page select register steers upper-half data decoding only.
// - Lower data half always hits local RAM.
module mma_map_arbiter #(
  parameter int unsigned NCPU = 2
) (
  // Clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  // Mode register writes
  input  wire logic [NCPU-1:0]                       overlay_wr,
  input  wire logic [NCPU-1:0]                       overlay_val,
  input  wire logic [NCPU-1:0]                       page_sel_wr,
  input  wire logic [NCPU-1:0]                       page_sel_val,
  // CPU data bus
  input  wire logic [NCPU-1:0]                       d_req,
  input  wire logic [NCPU-1:0]                       d_we,
  input  wire logic [NCPU-1:0][mma_pkg::WORD_W-1:0]  d_addr,
  input  wire logic [NCPU-1:0][mma_pkg::WORD_W-1:0]  d_wdata,
  output logic      [NCPU-1:0]                       d_ack,
  output logic      [NCPU-1:0][mma_pkg::WORD_W-1:0]  d_rdata,
  // CPU program bus
  input  wire logic [NCPU-1:0]                       p_req,
  input  wire logic [NCPU-1:0]                       p_we,
  input  wire logic [NCPU-1:0][mma_pkg::PADDR_W-1:0] p_addr,
  input  wire logic [NCPU-1:0][mma_pkg::WORD_W-1:0]  p_wdata,
  output logic      [NCPU-1:0]                       p_ack,
  output logic      [NCPU-1:0]                       p_err,
  output logic      [NCPU-1:0]                       p_wait,
  output logic      [NCPU-1:0][mma_pkg::WORD_W-1:0]  p_rdata,
  // Mode state seen by the CPUs
  output logic      [NCPU-1:0]                       overlay_enable,
  output logic      [NCPU-1:0]                       data_page_select,
  // Memory bus from DMA and host port
  input  wire logic                                  m_req,
  input  wire logic                                  m_we,
  input  wire logic [mma_pkg::MADDR_W-1:0]           m_addr,
  input  wire logic [mma_pkg::WORD_W-1:0]            m_wdata,
  output logic                                       m_ready,
  output logic                                       m_ack,
  output logic      [mma_pkg::WORD_W-1:0]            m_rdata
);

  localparam int unsigned DW = mma_pkg::WORD_W;
  localparam int unsigned LW = $clog2(mma_pkg::LOCAL_WORDS);
  localparam int unsigned SW = $clog2(mma_pkg::SHARED_WORDS);

  // Storage
  logic [DW-1:0] dual_access_ram [NCPU][mma_pkg::LOCAL_WORDS];
  logic [DW-1:0] shared_ram      [mma_pkg::SHARED_WORDS];

  // Mode registers
  logic [NCPU-1:0]          ovl_r;
  logic [NCPU-1:0]          ovl_nxt;
  logic [NCPU-1:0]          dps_r;
  logic [NCPU-1:0]          dps_nxt;

  // CPU answers
  logic [NCPU-1:0]          d_ack_r;
  logic [NCPU-1:0]          d_ack_nxt;
  logic [NCPU-1:0][DW-1:0]  d_rdata_r;
  logic [NCPU-1:0][DW-1:0]  d_rdata_nxt;
  logic [NCPU-1:0]          p_ack_r;
  logic [NCPU-1:0]          p_ack_nxt;
  logic [NCPU-1:0]          p_err_r;
  logic [NCPU-1:0]          p_err_nxt;
  logic [NCPU-1:0]          p_wait_r;
  logic [NCPU-1:0]          p_wait_nxt;
  logic [NCPU-1:0][DW-1:0]  p_rdata_r;
  logic [NCPU-1:0][DW-1:0]  p_rdata_nxt;

  // Decoded accesses
  logic [NCPU-1:0][LW-1:0]  d_idx;
  logic [NCPU-1:0][LW-1:0]  pl_idx;
  logic [NCPU-1:0][SW-1:0]  ps_idx;
  logic [NCPU-1:0]          p_local;
  logic [NCPU-1:0]          p_go;
  logic [NCPU-1:0]          p_ldw;
  logic [NCPU-1:0]          d_ldw;
  logic                     mb_block;
  logic                     sh_we;

  // Memory bus state
  mma_pkg::mma_mbus_e       mb_st_r;
  mma_pkg::mma_mbus_e       mb_st_nxt;
  logic                     mb_we_r;
  logic                     mb_we_nxt;
  logic [SW-1:0]            mb_addr_r;
  logic [SW-1:0]            mb_addr_nxt;
  logic [DW-1:0]            mb_wdata_r;
  logic [DW-1:0]            mb_wdata_nxt;
  logic                     m_ready_r;
  logic                     m_ready_nxt;
  logic                     m_ack_r;
  logic                     m_ack_nxt;
  logic [DW-1:0]            m_rdata_r;
  logic [DW-1:0]            m_rdata_nxt;

  // Memory bus sequencer: take, then two cycles to the answer
  always_comb begin
    mb_st_nxt    = mb_st_r;
    mb_we_nxt    = mb_we_r;
    mb_addr_nxt  = mb_addr_r;
    mb_wdata_nxt = mb_wdata_r;
    m_ack_nxt    = 1'b0;
    m_rdata_nxt  = m_rdata_r;
    unique case (mb_st_r)
      mma_pkg::MB_IDLE: begin
        if (m_req && m_ready_r) begin
          mb_st_nxt    = mma_pkg::MB_FIRST;
          mb_we_nxt    = m_we;
          mb_addr_nxt  = m_addr[SW-1:0];
          mb_wdata_nxt = m_wdata;
        end
      end
      // Write lands and read data is taken in the first cycle
      mma_pkg::MB_FIRST: begin
        mb_st_nxt = mma_pkg::MB_SECOND;
        if (!mb_we_r) begin
          m_rdata_nxt = shared_ram[mb_addr_r];
        end
      end
      mma_pkg::MB_SECOND: begin
        mb_st_nxt = mma_pkg::MB_IDLE;
        m_ack_nxt = 1'b1;
      end
    endcase
    m_ready_nxt = (mb_st_nxt == mma_pkg::MB_IDLE);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mb_st_r    <= mma_pkg::MB_IDLE;
      mb_we_r    <= 1'b0;
      mb_addr_r  <= '0;
      mb_wdata_r <= '0;
      m_ready_r  <= 1'b1;
      m_ack_r    <= 1'b0;
      m_rdata_r  <= '0;
    end else begin
      mb_st_r    <= mb_st_nxt;
      mb_we_r    <= mb_we_nxt;
      mb_addr_r  <= mb_addr_nxt;
      mb_wdata_r <= mb_wdata_nxt;
      m_ready_r  <= m_ready_nxt;
      m_ack_r    <= m_ack_nxt;
      m_rdata_r  <= m_rdata_nxt;
    end
  end

  // A pending or arriving bus transfer holds shared fetches off
  assign mb_block = m_req || (mb_st_r != mma_pkg::MB_IDLE);

  // Shared RAM write strobe, in the first transfer cycle
  assign sh_we = (mb_st_r == mma_pkg::MB_FIRST) && mb_we_r;

  // Per-CPU decode and answers
  always_comb begin
    for (int i = 0; i < NCPU; i++) begin
      logic [2:0] dblk;
      logic [1:0] sblk;
      logic       low;
      logic       resv;
      dblk = '0;
      sblk = '0;
      low  = 1'b0;
      resv = 1'b0;

      // Writes land in the register, decode keeps the old value
      ovl_nxt[i] = overlay_wr[i]  ? overlay_val[i]  : ovl_r[i];
      dps_nxt[i] = page_sel_wr[i] ? page_sel_val[i] : dps_r[i];

      // Data space
      if (!d_addr[i][DW-1]) begin
        dblk = {2'b00, d_addr[i][DW-2]};
      end else begin
        dblk = 3'(mma_pkg::DATA_UPPER_BASE
               + {1'b0, dps_r[i], 1'b0}
               + {2'b00, d_addr[i][DW-2]});
      end
      d_idx[i] = {dblk, d_addr[i][mma_pkg::LOCAL_OFF_W-1:0]};
      // Data accesses are never stalled
      d_ack_nxt[i]   = d_req[i];
      d_ldw[i]       = d_req[i] && d_we[i];
      d_rdata_nxt[i] = d_rdata_r[i];
      if (d_req[i] && !d_we[i]) begin
        d_rdata_nxt[i] = dual_access_ram[i][d_idx[i]];
      end

      // Program space
      low        = !p_addr[i][DW-1];
      p_local[i] = low && ovl_r[i];
      // Low half without overlay fetches from shared page 3
      sblk       = low ? mma_pkg::PROG_LOW_PAGE
                       : p_addr[i][mma_pkg::PADDR_W-1:DW];
      // Upper half of page 3 is reserved while the overlay is off
      resv       = !low && !ovl_r[i]
                   && (sblk == mma_pkg::PROG_LOW_PAGE);
      ps_idx[i]  = {sblk, p_addr[i][mma_pkg::SHARED_OFF_W-1:0]};
      pl_idx[i]  = {2'b00, p_addr[i][mma_pkg::SHARED_OFF_W-1:0]};

      // Overlay fetches use the local port and never wait
      p_go[i]    = p_req[i] && (p_local[i] || !mb_block);
      p_ldw[i]   = p_go[i] && p_we[i] && p_local[i];
      p_ack_nxt[i]  = p_go[i];
      p_err_nxt[i]  = p_go[i]
                      && (resv || (p_we[i] && !p_local[i]));
      p_wait_nxt[i] = p_req[i] && !p_go[i];

      // A reserved read leaves p_rdata unchanged
      p_rdata_nxt[i] = p_rdata_r[i];
      if (p_go[i] && !p_we[i]) begin
        if (p_local[i]) begin
          p_rdata_nxt[i] = dual_access_ram[i][pl_idx[i]];
        end else if (!resv) begin
          p_rdata_nxt[i] = shared_ram[ps_idx[i]];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovl_r     <= {NCPU{mma_pkg::OVERLAY_RST}};
      dps_r     <= {NCPU{mma_pkg::PAGE_SEL_RST}};
      d_ack_r   <= '0;
      d_rdata_r <= '0;
      p_ack_r   <= '0;
      p_err_r   <= '0;
      p_wait_r  <= '0;
      p_rdata_r <= '0;
    end else begin
      ovl_r     <= ovl_nxt;
      dps_r     <= dps_nxt;
      d_ack_r   <= d_ack_nxt;
      d_rdata_r <= d_rdata_nxt;
      p_ack_r   <= p_ack_nxt;
      p_err_r   <= p_err_nxt;
      p_wait_r  <= p_wait_nxt;
      p_rdata_r <= p_rdata_nxt;
    end
  end

  // Local RAM: data port and overlay program port in the same cycle
  // Memory contents survive sys_rst
  always_ff @(posedge clk) begin
    for (int i = 0; i < NCPU; i++) begin
      if (p_ldw[i]) begin
        dual_access_ram[i][pl_idx[i]] <= p_wdata[i];
      end
      if (d_ldw[i]) begin
        dual_access_ram[i][d_idx[i]] <= d_wdata[i];
      end
    end
  end

  // Shared RAM is written by the memory bus only
  always_ff @(posedge clk) begin
    if (sh_we) begin
      shared_ram[mb_addr_r] <= mb_wdata_r;
    end
  end

  assign d_ack            = d_ack_r;
  assign d_rdata          = d_rdata_r;
  assign p_ack            = p_ack_r;
  assign p_err            = p_err_r;
  assign p_wait           = p_wait_r;
  assign p_rdata          = p_rdata_r;
  assign overlay_enable   = ovl_r;
  assign data_page_select = dps_r;
  assign m_ready          = m_ready_r;
  assign m_ack            = m_ack_r;
  assign m_rdata          = m_rdata_r;

endmodule

/* File: testbench/mma_map_asserts.sv */
/* Checker of CPU 0, the paired CPU shared fetch and memory bus timing of the map arbiter.
   Bound into mma_map_arbiter; sees its ports only. */
`timescale 1ns/1ps
module mma_map_asserts #(
  parameter int unsigned NCPU = 2
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  // CPU side
  input wire logic [NCPU-1:0]       overlay_wr,
  input wire logic [NCPU-1:0]       overlay_val,
  input wire logic [NCPU-1:0]       overlay_enable,
  input wire logic [NCPU-1:0]       d_req,
  input wire logic [NCPU-1:0]       d_ack,
  input wire logic [NCPU-1:0]       p_req,
  input wire logic [NCPU-1:0]       p_we,
  input wire logic [NCPU-1:0][17:0] p_addr,
  input wire logic [NCPU-1:0]       p_ack,
  input wire logic [NCPU-1:0]       p_err,
  input wire logic [NCPU-1:0]       p_wait,
  // Memory bus
  input wire logic                  m_req,
  input wire logic                  m_ready,
  input wire logic                  m_ack
);
  logic shr0;
  logic idle;
  // Shared read fetch of CPU 0, and a free memory bus
  assign shr0 = p_req[0] && !p_we[0] && (p_addr[0][15] || !overlay_enable[0]);
  assign idle = !m_req && m_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_dack_pulse: assert property (d_req[0] |=> d_ack[0])
    else $error("data ack missing");
  a_dack_cause: assert property (d_ack[0] |-> $past(d_req[0]))
    else $error("data ack without request");
  a_mbus_length: assert property (m_req && m_ready |=>
    !m_ready [*2] ##1 (m_ready && m_ack)) else $error("bus length");
  a_mack_cause: assert property (m_ack |-> $past(m_req, 3))
    else $error("bus ack without request");
  a_fetch_stall: assert property (shr0 && m_req |=>
    p_wait[0] && !p_ack[0]) else $error("fetch not stalled");
  a_busy_stall: assert property (shr0 && !m_ready |=> !p_ack[0])
    else $error("fetch during transfer");
  a_cpu_wrerr: assert property (p_req[0] && p_we[0] && p_addr[0][15]
    && idle |=> p_ack[0] && p_err[0]) else $error("shared write taken");
  a_dual_fetch: assert property (shr0 && p_req[1] && !p_we[1]
    && p_addr[1][15] && idle |=> &p_ack) else $error("fetch pair stalled");
  a_overlay_enable_write: assert property (overlay_wr[0] |=>
    overlay_enable[0] == $past(overlay_val[0])) else $error("overlay bit");
  c_stall: cover property (shr0 && m_req);
  c_mack: cover property (m_ack);
  c_perr: cover property (p_err[0]);
endmodule

bind mma_map_arbiter mma_map_asserts #(.NCPU(NCPU)) u_mma_map_asserts (
  .clk(clk), .sys_rst(sys_rst), .overlay_wr(overlay_wr),
  .overlay_val(overlay_val), .overlay_enable(overlay_enable),
  .d_req(d_req), .d_ack(d_ack), .p_req(p_req), .p_we(p_we),
  .p_addr(p_addr), .p_ack(p_ack), .p_err(p_err), .p_wait(p_wait),
  .m_req(m_req), .m_ready(m_ready), .m_ack(m_ack));

/* File: testbench/mma_mbus_model.sv */
/* Memory bus master standing for the DMA and host port.
   The bench calls xfer; signals change at the falling edge of clk. */
`timescale 1ns/1ps
module mma_mbus_model (
  // Clock
  input  wire logic        clk,
  // Answer
  input  wire logic        m_ready,
  input  wire logic        m_ack,
  input  wire logic [15:0] m_rdata,
  // Request
  output logic             m_req,
  output logic             m_we,
  output logic      [16:0] m_addr,
  output logic      [15:0] m_wdata
);
  initial begin
    m_req = 1'b0;
    m_we = 1'b0;
    m_addr = 17'h0;
    m_wdata = 16'h0;
  end
  task automatic xfer(input logic we, input logic [16:0] a,
                      input logic [15:0] w, output logic [15:0] rd,
                      output int lat);
    lat = 0;
    @(negedge clk);
    m_req = 1'b1;
    m_we = we;
    m_addr = a;
    m_wdata = w;
    repeat (8) begin
      @(posedge clk);
      if (m_ready === 1'b1) break;
    end
    // Released lines show the inverse, never the old value
    @(negedge clk);
    m_req = 1'b0;
    m_we = ~we;
    m_addr = ~a;
    m_wdata = ~w;
    while (m_ack !== 1'b1 && lat < 8) begin
      @(negedge clk);
      lat++;
    end
    rd = m_rdata;
  endtask
endmodule

/* File: testbench/testbench.sv */
/* Self-checking bench of the map arbiter with a memory bus model.
   Needs mma_pkg, the design and the bound checker. */
`timescale 1ns/1ps
module testbench;
  typedef struct { logic dps; logic [15:0] a; logic [15:0] w; } mma_row_s;
  logic             clk, sys_rst, m_req, m_we, m_ready, m_ack, err;
  logic [1:0]       overlay_wr, overlay_val, page_sel_wr, page_sel_val;
  logic [1:0]       d_req, d_we, d_ack, p_req, p_we, p_ack, p_err, p_wait;
  logic [1:0]       overlay_enable, data_page_select;
  logic [1:0][15:0] d_addr, d_wdata, d_rdata, p_wdata, p_rdata;
  logic [1:0][17:0] p_addr;
  logic [16:0]      m_addr;
  logic [15:0]      m_wdata, m_rdata, rd, mrd;
  int               num_errors, samples_checked, lat, waits;
  mma_row_s         rows [6] = '{'{1'b0, 16'h8000, 16'h1a01},
    '{1'b1, 16'h8000, 16'h1a02}, '{1'b0, 16'hc123, 16'h1a03},
    '{1'b1, 16'hc123, 16'h1a04}, '{1'b0, 16'h0123, 16'h1a05},
    '{1'b1, 16'h4123, 16'h1a06}};
  mma_map_arbiter u_mma_map_arbiter (.clk(clk), .sys_rst(sys_rst),
    .overlay_wr(overlay_wr), .overlay_val(overlay_val),
    .page_sel_wr(page_sel_wr), .page_sel_val(page_sel_val), .d_req(d_req),
    .d_we(d_we), .d_addr(d_addr), .d_wdata(d_wdata), .d_ack(d_ack),
    .d_rdata(d_rdata), .p_req(p_req), .p_we(p_we), .p_addr(p_addr),
    .p_wdata(p_wdata), .p_ack(p_ack), .p_err(p_err), .p_wait(p_wait),
    .p_rdata(p_rdata), .overlay_enable(overlay_enable),
    .data_page_select(data_page_select), .m_req(m_req), .m_we(m_we),
    .m_addr(m_addr), .m_wdata(m_wdata), .m_ready(m_ready), .m_ack(m_ack),
    .m_rdata(m_rdata));
  mma_mbus_model u_mma_mbus_model (.clk(clk), .m_ready(m_ready),
    .m_ack(m_ack), .m_rdata(m_rdata), .m_req(m_req), .m_we(m_we),
    .m_addr(m_addr), .m_wdata(m_wdata));
  task automatic check(string n, logic [15:0] s, logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic setmode(logic ov, logic dps);
    @(negedge clk);
    overlay_wr = 2'h3;
    overlay_val = {2{ov}};
    page_sel_wr = 2'h3;
    page_sel_val = {2{dps}};
    @(negedge clk);
    overlay_wr = 2'h0;
    page_sel_wr = 2'h0;
    check("dps", 16'(data_page_select), 16'({2{dps}}));
  endtask
  task automatic dacc(logic we, logic [15:0] a, logic [15:0] w);
    @(negedge clk);
    d_req[0] = 1'b1;
    d_we[0] = we;
    d_addr[0] = a;
    d_wdata[0] = w;
    @(negedge clk);
    d_req[0] = 1'b0;
    d_addr[0] = ~a;
    check("d_ack", 16'(d_ack), 16'h1);
    rd = d_rdata[0];
  endtask
  task automatic pacc(logic [1:0] cm, logic we, logic [17:0] a);
    @(negedge clk);
    p_req = cm;
    p_we = {2{we}};
    p_addr = {a, a};
    waits = 0;
    repeat (20) begin
      @(negedge clk);
      if (p_ack[0] === 1'b1) break;
      if (p_wait[0] === 1'b1) waits++;
    end
    check("p_ack", 16'(p_ack), 16'(cm));
    err = p_err[0];
    rd = p_rdata[0];
    p_req = 2'h0;
    p_addr = ~{a, a};
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    {overlay_wr, overlay_val, page_sel_wr, page_sel_val} = 8'h0;
    {d_req, d_we, p_req, p_we, d_addr, d_wdata, p_wdata, p_addr} = '0;
    p_wdata = {2{16'hdead}};
    sys_rst = 1'b1;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    check("overlay_enable_rst", 16'(overlay_enable), 16'h0);
    foreach (rows[i]) begin
      setmode(1'b0, rows[i].dps);
      dacc(1'b1, rows[i].a, rows[i].w);
    end
    foreach (rows[i]) begin
      setmode(1'b0, rows[i].dps);
      dacc(1'b0, rows[i].a, 16'h0);
      check("d_rdata", rd, rows[i].w);
    end
    $display("decode rows done");
    setmode(1'b0, 1'b1);
    dacc(1'b0, 16'h0123, 16'h0);
    check("low_half", rd, 16'h1a05);
    u_mma_mbus_model.xfer(1'b1, 17'h18000, 16'h5a03, mrd, lat);
    check("m_len", 16'(lat), 16'(mma_pkg::MBUS_CYCLES));
    u_mma_mbus_model.xfer(1'b1, 17'h10005, 16'h5a02, mrd, lat);
    setmode(1'b0, 1'b0);
    pacc(2'h3, 1'b0, 18'h00000);
    check("pg3_low", rd, 16'h5a03);
    pacc(2'h3, 1'b0, 18'h28005);
    check("pg2", rd, 16'h5a02);
    check("pg2_cpu1", p_rdata[1], 16'h5a02);
    pacc(2'h1, 1'b0, 18'h38005);
    check("reserved", 16'(err), 16'h1);
    pacc(2'h1, 1'b1, 18'h28005);
    check("cpu_wr", 16'(err), 16'h1);
    u_mma_mbus_model.xfer(1'b0, 17'h10005, 16'h0, mrd, lat);
    check("no_write", mrd, 16'h5a02);
    setmode(1'b1, 1'b0);
    pacc(2'h1, 1'b0, 18'h20123);
    check("overlay", rd, 16'h1a05);
    fork
      u_mma_mbus_model.xfer(1'b1, 17'h10006, 16'h5a04, mrd, lat);
      pacc(2'h1, 1'b0, 18'h28005);
    join
    check("stall", 16'(waits), 16'h3);
    check("stall_rd", rd, 16'h5a02);
    $display("hand tests done");
    @(negedge clk);
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    check("overlay_enable_rst2", 16'(overlay_enable), 16'h0);
    check("m_ready_rst", 16'(m_ready), 16'h1);
    $display("reset test done");
    stop_test();
  end
endmodule
